// [host_link_model.sv]
// host model: packet sink with stalls, user storage, save answer
`timescale 1ns/10ps
module host_link_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic save_good,
    input wire logic [127:0] nv_user_wr,
    input wire logic nv_user_we,
    output logic [127:0] nv_user_rd,
    input wire logic nv_save_req,
    output logic nv_save_done,
    output logic nv_save_match,
    output logic tx_ready
);
    logic [1:0] tick_r;
    logic [2:0] save_r;
    assign tx_ready = !slow || tick_r == 2'h3;
    assign nv_save_done = save_r[2];
    assign nv_save_match = save_good;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick_r <= 2'h0;
            save_r <= 3'h0;
        end else begin
            tick_r <= tick_r + 2'h1;
            save_r <= {save_r[1:0], nv_save_req};
        end
    end
    always_ff @(posedge clk)
        if (nv_user_we) nv_user_rd <= nv_user_wr;
endmodule

// [module_packet_command_handler.sv]
// packet command interpreter with periodic fan and temperature reports
`timescale 1ns/10ps
module module_packet_command_handler
    import pkt_cmd_pkg::*;
#(
    parameter int HOST_PWR_MS = 1000,
    parameter int MS_CYCLES = TICK_1MS,
    parameter logic [127:0] VERSION_STR = 128'h30313233343536373839414243444546 // arbitrary value
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire pkt_t cmd_pkt,
    output pkt_t tx_pkt,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [3:0] fan_report_en,
    input wire logic [31:0] temp_report_en,
    input wire logic board_present,
    input wire fan_meas_t fan_meas [4],
    input wire temp_meas_t temp_meas [32],
    output logic [127:0] nv_user_wr,
    output logic nv_user_we,
    input wire logic [127:0] nv_user_rd,
    output logic nv_save_req,
    input wire logic nv_save_done,
    input wire logic nv_save_match,
    output logic cfg_load_req,
    output logic [7:0] screen_char_memory_wdata,
    output logic [6:0] screen_char_memory_addr,
    output logic screen_char_memory_we,
    output logic cursor_home,
    output logic host_reset_drive,
    output logic host_power_drive,
    output logic fans_on,
    output logic cmd_busy
);
    typedef enum logic [6:0] {
        S_IDLE = 7'b0000001,
        S_SAVE = 7'b0000010,
        S_CLEAR = 7'b0000100,
        S_HRST = 7'b0001000,
        S_HPWR = 7'b0010000,
        S_BOOT = 7'b0100000,
        S_SEND = 7'b1000000
    } st_t;
    st_t st_r;
    logic [16:0] ms_cnt_r;
    logic ms_tick_r;
    logic [11:0] ms_r;
    logic [11:0] boot_ms_r;
    logic [8:0] fan_ms_r;
    logic [9:0] temp_ms_r;
    logic [3:0] fan_pend_r;
    logic [31:0] temp_pend_r;
    logic [4:0] temp_idx_r;
    logic [1:0] fan_idx_r;
    logic [6:0] clr_addr_r;
    logic [11:0] wait_ms_r;
    logic [7:0] ans_code_r;
    logic do_reboot_r;
    pkt_t ans_r;
    logic ans_pend_r;
    pkt_t fifo_in;
    logic fifo_valid;
    logic fifo_ready;
    logic fifo_out_valid;
    logic [$bits(pkt_t)-1:0] fifo_out;
    logic fifo_take;
    logic cmd_take;

    function automatic logic len_ok(input logic [5:0] c, input logic [7:0] l);
        logic ok;
        ok = 1'b0;
        case (c)
            C_PING: ok = (l <= PING_MAX);
            C_UWR: ok = (l == USER_LEN);
            C_BOOT: ok = (l == 8'h03);
            C_VER, C_URD, C_SAVE, C_CLR: ok = (l == 8'h00);
            default: ok = 1'b0;
        endcase
        return ok && (l <= MAX_LEN);
    endfunction

    function automatic pkt_t mk(input logic [7:0] k, input logic [7:0] l, input logic [175:0] d);
        pkt_t p;
        p.kind = k;
        p.len = l;
        p.data = d;
        return p;
    endfunction

    // millisecond enable
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_cnt_r <= '0;
            ms_tick_r <= 1'b0;
        end else begin
            ms_tick_r <= (ms_cnt_r == 17'(MS_CYCLES - 1));
            ms_cnt_r <= (ms_cnt_r == 17'(MS_CYCLES - 1)) ? '0 : 17'(ms_cnt_r + 1'b1);
        end
    end

    // power-up sequencing, fans after delay
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            boot_ms_r <= '0;
            fans_on <= 1'b0;
            cfg_load_req <= 1'b1;
        end else if (do_reboot_r) begin
            boot_ms_r <= '0;
            fans_on <= 1'b0;
            cfg_load_req <= 1'b1;
        end else begin
            cfg_load_req <= 1'b0;
            if (ms_tick_r && boot_ms_r != 12'(FAN_DELAY_MS)) begin
                boot_ms_r <= 12'(boot_ms_r + 1'b1);
            end
            fans_on <= (boot_ms_r == 12'(FAN_DELAY_MS));
        end
    end

    // report timers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            fan_ms_r <= '0;
            temp_ms_r <= '0;
            fan_pend_r <= '0;
            temp_pend_r <= '0;
            fan_idx_r <= '0;
            temp_idx_r <= '0;
        end else begin
            if (ms_tick_r) begin
                fan_ms_r <= (fan_ms_r == 9'(FAN_PERIOD_MS - 1)) ? '0 : 9'(fan_ms_r + 1'b1);
                temp_ms_r <= (temp_ms_r == 10'(TEMP_PERIOD_MS - 1)) ? '0 : 10'(temp_ms_r + 1'b1);
            end
            if (ms_tick_r && fan_ms_r == 9'(FAN_PERIOD_MS - 1)) begin
                fan_pend_r <= fan_report_en;
            end else if (fifo_valid && !ans_pend_r && fan_pend_r[fan_idx_r]) begin
                fan_pend_r[fan_idx_r] <= 1'b0;
            end
            if (!fan_pend_r[fan_idx_r] || (fifo_valid && fifo_ready && !ans_pend_r)) begin
                fan_idx_r <= 2'(fan_idx_r + 1'b1);
            end
            if (ms_tick_r && temp_ms_r == 10'(TEMP_PERIOD_MS - 1)) begin
                temp_pend_r <= temp_report_en;
            end else if (fifo_valid && !ans_pend_r && fan_pend_r == '0 && temp_pend_r[temp_idx_r]) begin
                temp_pend_r[temp_idx_r] <= 1'b0;
            end
            if (!temp_pend_r[temp_idx_r] || (fifo_valid && fifo_ready && !ans_pend_r && fan_pend_r == '0)) begin
                temp_idx_r <= 5'(temp_idx_r + 1'b1);
            end
        end
    end

    // packet source mux into fifo: answers first, then fans, then temps
    always_comb begin
        fifo_in = ans_r;
        fifo_valid = ans_pend_r;
        if (!ans_pend_r && fan_pend_r[fan_idx_r]) begin
            fifo_valid = fifo_ready;
            fifo_in = mk(T_FAN_RPT, 8'h04, {6'h00, fan_idx_r,
                board_present ? fan_meas[fan_idx_r].tach : 8'h00,
                board_present ? fan_meas[fan_idx_r].ticks : 16'h0000, 144'h0});
        end else if (!ans_pend_r && fan_pend_r == '0 && temp_pend_r[temp_idx_r]) begin
            fifo_valid = fifo_ready;
            fifo_in = mk(T_TEMP_RPT, 8'h04, {3'h0, temp_idx_r, temp_meas[temp_idx_r].counts,
                temp_meas[temp_idx_r].crc_ok ? 8'h01 : 8'h00, 144'h0});
        end
    end

    pkt_fifo #(.WIDTH($bits(pkt_t)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_valid(fifo_valid),
        .in_ready(fifo_ready),
        .in_data(fifo_in),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_take),
        .out_data(fifo_out)
    );

    // output register stage, held until the host link takes it with tx_ready
    assign fifo_take = fifo_out_valid && (!tx_valid || tx_ready);
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tx_valid <= 1'b0;
            tx_pkt <= '0;
        end else if (fifo_take) begin
            tx_valid <= 1'b1;
            tx_pkt <= fifo_out;
        end else if (tx_ready) begin
            tx_valid <= 1'b0;
        end
    end

    // a command is only taken once the previous answer has reached the fifo
    assign cmd_take = (st_r == S_IDLE) && cmd_valid && !(ans_pend_r && !fifo_ready);

    // command state machine
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= S_IDLE;
            ans_r <= '0;
            ans_pend_r <= 1'b0;
            ans_code_r <= '0;
            nv_user_wr <= '0;
            nv_user_we <= 1'b0;
            nv_save_req <= 1'b0;
            clr_addr_r <= '0;
            screen_char_memory_we <= 1'b0;
            screen_char_memory_addr <= '0;
            screen_char_memory_wdata <= '0;
            cursor_home <= 1'b0;
            host_reset_drive <= 1'b0;
            host_power_drive <= 1'b0;
            wait_ms_r <= '0;
            do_reboot_r <= 1'b0;
            cmd_busy <= 1'b0;
        end else begin
            nv_user_we <= 1'b0;
            nv_save_req <= 1'b0;
            screen_char_memory_we <= 1'b0;
            cursor_home <= 1'b0;
            do_reboot_r <= 1'b0;
            if (ans_pend_r && fifo_ready) begin
                ans_pend_r <= 1'b0;
            end
            case (st_r)
                S_IDLE: begin
                    cmd_busy <= ans_pend_r && !fifo_ready;
                    if (cmd_take) begin
                        cmd_busy <= 1'b1;
                        ans_code_r <= {2'b00, cmd_pkt.kind[5:0]};
                        st_r <= S_SEND;
                        ans_r <= mk(T_RESP | {2'b00, cmd_pkt.kind[5:0]}, 8'h00, '0);
                        if (!len_ok(cmd_pkt.kind[5:0], cmd_pkt.len) || cmd_pkt.kind[7:6] != 2'b00) begin
                            ans_r <= mk(T_ERR | {2'b00, cmd_pkt.kind[5:0]}, 8'h00, '0);
                        end else begin
                            case (cmd_pkt.kind[5:0])
                                C_PING: ans_r <= mk(T_RESP, cmd_pkt.len, cmd_pkt.data);
                                C_VER: ans_r <= mk(T_RESP | 8'h01, USER_LEN, {VERSION_STR, 48'h0});
                                C_UWR: begin
                                    nv_user_wr <= cmd_pkt.data[175:48];
                                    nv_user_we <= 1'b1;
                                end
                                C_URD: ans_r <= mk(T_RESP | 8'h03, USER_LEN, {nv_user_rd, 48'h0});
                                C_SAVE: begin
                                    nv_save_req <= 1'b1;
                                    st_r <= S_SAVE;
                                end
                                C_CLR: begin
                                    clr_addr_r <= '0;
                                    st_r <= S_CLEAR;
                                end
                                C_BOOT: begin
                                    if (cmd_pkt.data[175:152] == 24'h081263) begin
                                        st_r <= S_BOOT;
                                    end else if (cmd_pkt.data[175:152] == 24'h0C1C61) begin
                                        wait_ms_r <= 12'(HRST_PULSE_MS);
                                        ans_pend_r <= 1'b1;
                                        st_r <= S_HRST;
                                    end else if (cmd_pkt.data[175:152] == 24'h030B5F) begin
                                        wait_ms_r <= 12'(HOST_PWR_MS);
                                        ans_pend_r <= 1'b1;
                                        st_r <= S_HPWR;
                                    end else begin
                                        ans_r <= mk(T_ERR | 8'h05, 8'h00, '0);
                                    end
                                end
                                default: ans_r <= mk(T_ERR | {2'b00, cmd_pkt.kind[5:0]}, 8'h00, '0);
                            endcase
                        end
                    end
                end
                S_SAVE: begin
                    if (nv_save_done) begin
                        if (!nv_save_match) begin
                            ans_r <= mk(T_ERR | 8'h04, 8'h00, '0);
                        end
                        st_r <= S_SEND;
                    end
                end
                S_CLEAR: begin
                    screen_char_memory_we <= 1'b1;
                    screen_char_memory_addr <= clr_addr_r;
                    screen_char_memory_wdata <= BLANK_CHAR;
                    clr_addr_r <= 7'(clr_addr_r + 1'b1);
                    if (clr_addr_r == 7'(SCREEN_CELLS - 1)) begin
                        cursor_home <= 1'b1;
                        st_r <= S_SEND;
                    end
                end
                S_HRST, S_HPWR: begin
                    if (!ans_pend_r) begin
                        host_reset_drive <= (st_r == S_HRST);
                        host_power_drive <= (st_r == S_HPWR);
                        if (ms_tick_r) begin
                            wait_ms_r <= 12'(wait_ms_r - 1'b1);
                        end
                        if (wait_ms_r == '0) begin
                            host_reset_drive <= 1'b0;
                            host_power_drive <= 1'b0;
                            do_reboot_r <= 1'b1;
                            cmd_busy <= 1'b0;
                            st_r <= S_IDLE;
                        end
                    end
                end
                S_BOOT: begin
                    do_reboot_r <= 1'b1;
                    st_r <= S_SEND;
                end
                S_SEND: begin
                    ans_pend_r <= 1'b1;
                    st_r <= S_IDLE;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // answer deadline watch
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ms_r <= '0;
        end else if (!cmd_busy || st_r == S_HRST || st_r == S_HPWR) begin
            ms_r <= '0;
        end else if (ms_tick_r) begin
            ms_r <= 12'(ms_r + 1'b1);
        end
    end

    chk_answer_deadline: assert property (@(posedge clk) disable iff (sys_rst)
        ms_r <= 12'(ANSWER_LIMIT_MS)) else $error("answer later than limit");
    chk_fans_delay: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(fans_on) |-> boot_ms_r == 12'(FAN_DELAY_MS)) else $error("fans on early");
    chk_fan_type: assert property (@(posedge clk) disable iff (sys_rst)
        (fifo_valid && fifo_in.kind == T_FAN_RPT) |-> fifo_in.len == 8'h04) else $error("fan report length");
    chk_fan_absent: assert property (@(posedge clk) disable iff (sys_rst)
        (fifo_valid && fifo_in.kind == T_FAN_RPT && !board_present) |-> fifo_in.data[167:144] == 24'h0)
        else $error("absent board nonzero data");
    chk_temp_crc: assert property (@(posedge clk) disable iff (sys_rst)
        (fifo_valid && fifo_in.kind == T_TEMP_RPT && !temp_meas[temp_idx_r].crc_ok) |-> fifo_in.data[151:144] == 8'h00)
        else $error("bad crc not zero");
    sequence seq_cmd_in;
        cmd_take;
    endsequence
    chk_low_bits_match: assert property (@(posedge clk) disable iff (sys_rst)
        seq_cmd_in ##1 st_r == S_SEND |=> ans_pend_r && ans_r.kind[5:0] == ans_code_r[5:0])
        else $error("answer type mismatch");
    chk_ping_echo: assert property (@(posedge clk) disable iff (sys_rst)
        (cmd_take && cmd_pkt.kind == 8'h00 && cmd_pkt.len <= PING_MAX) |=> ans_r.len == $past(cmd_pkt.len))
        else $error("ping length not echoed");
    chk_clear_blank: assert property (@(posedge clk) disable iff (sys_rst)
        screen_char_memory_we |-> screen_char_memory_wdata == BLANK_CHAR) else $error("clear not blank");
    chk_host_reset: assert property (@(posedge clk) disable iff (sys_rst)
        host_reset_drive |-> st_r == S_HRST) else $error("reset drive outside sequence");
endmodule

// [pkt_cmd_pkg.sv]
// package: constants and carrier types for the packet command handler
package pkt_cmd_pkg;
    localparam int CLK_HZ = 100000000;
    localparam int FAN_PERIOD_MS = 500;
    localparam int TEMP_PERIOD_MS = 1000;
    localparam int FAN_DELAY_MS = 520;
    localparam int HRST_PULSE_MS = 1500;
    localparam int ANSWER_LIMIT_MS = 250;
    localparam int BOOT_ACK_MS = 3000;
    localparam int TICK_1MS = CLK_HZ / 1000;
    localparam logic [7:0] T_FAN_RPT = 8'h81;
    localparam logic [7:0] T_TEMP_RPT = 8'h82;
    localparam logic [7:0] T_RESP = 8'h40;
    localparam logic [7:0] T_ERR = 8'hC0;
    localparam logic [5:0] C_PING = 6'h00;
    localparam logic [5:0] C_VER = 6'h01;
    localparam logic [5:0] C_UWR = 6'h02;
    localparam logic [5:0] C_URD = 6'h03;
    localparam logic [5:0] C_SAVE = 6'h04;
    localparam logic [5:0] C_BOOT = 6'h05;
    localparam logic [5:0] C_CLR = 6'h06;
    localparam logic [7:0] MAX_LEN = 8'h16;
    localparam logic [7:0] PING_MAX = 8'h10;
    localparam logic [7:0] USER_LEN = 8'h10;
    localparam logic [7:0] BLANK_CHAR = 8'h20;
    localparam int SCREEN_CELLS = 80;
    localparam int FIFO_DEPTH = 4;
    typedef struct packed {
        logic [7:0] kind;
        logic [7:0] len;
        logic [22*8-1:0] data;
    } pkt_t;
    typedef struct packed {
        logic [7:0] tach;
        logic [15:0] ticks;
    } fan_meas_t;
    typedef struct packed {
        logic [15:0] counts;
        logic crc_ok;
    } temp_meas_t;
endpackage

// [pkt_fifo.sv]
// FIFO of packets on the way out
`timescale 1ns/10ps
module pkt_fifo #(
    parameter int WIDTH = 192,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_r;
    logic [AW-1:0] rp_r;
    logic [AW:0] cnt_r;
    logic push;
    logic pop;
    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = (cnt_r != '0);
    assign out_data = mem[rp_r];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r] <= in_data;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wp_r <= AW'(wp_r + 1'b1);
            end
            if (pop) begin
                rp_r <= AW'(rp_r + 1'b1);
            end
            cnt_r <= (AW+1)'(cnt_r + push - pop);
        end
    end
endmodule

// [tb.sv]
// self-checking bench for the packet command handler
`timescale 1ns/10ps
module tb;
    import pkt_cmd_pkg::*;
    localparam int MS = 10;
    localparam int PWR_MS = 20;
    localparam logic [127:0] VER = 128'h0123456789ABCDEF0123456789ABCDEF; // arbitrary value
    localparam logic [175:0] PAT = {128'h00112233445566778899AABBCCDDEEFF, 48'h0};
    localparam logic [15:0] BAD [5] = '{16'h3F00, 16'h0101, 16'h0011, 16'h0017, 16'h0201};
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic cmd_valid = 1'h0;
    logic board_present = 1'h1;
    logic slow = 1'h1;
    logic save_good = 1'h1;
    logic tx_valid, tx_ready, nv_user_we, nv_save_req, nv_save_done, nv_save_match, cfg_load_req;
    logic cursor_home, screen_char_memory_we, host_reset_drive, host_power_drive, fans_on, cmd_busy;
    pkt_t cmd_pkt = '0;
    pkt_t tx_pkt;
    logic [3:0] fan_report_en = 4'h0;
    logic [31:0] temp_report_en = 32'h0;
    fan_meas_t fan_meas [4];
    temp_meas_t temp_meas [32];
    logic [127:0] nv_user_wr, nv_user_rd;
    logic [7:0] screen_char_memory_wdata;
    logic [6:0] screen_char_memory_addr;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int blanks = 0;
    int homes = 0;
    int a, b, n;
    pkt_t ans_q[$], rpt_q[$];
    int rpt_t[$];
    module_packet_command_handler #(.HOST_PWR_MS(PWR_MS), .MS_CYCLES(MS), .VERSION_STR(VER)) i_dut (
        .clk, .sys_rst, .cmd_valid, .cmd_pkt, .tx_pkt, .tx_valid, .tx_ready, .fan_report_en,
        .temp_report_en, .board_present, .fan_meas, .temp_meas, .nv_user_wr, .nv_user_we,
        .nv_user_rd, .nv_save_req, .nv_save_done, .nv_save_match, .cfg_load_req,
        .screen_char_memory_wdata, .screen_char_memory_addr, .screen_char_memory_we,
        .cursor_home, .host_reset_drive, .host_power_drive, .fans_on, .cmd_busy);
    host_link_model i_host (.clk, .sys_rst, .slow, .save_good, .nv_user_wr, .nv_user_we,
        .nv_user_rd, .nv_save_req, .nv_save_done, .nv_save_match, .tx_ready);
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (tx_valid === 1'h1 && tx_ready === 1'h1) begin
            if (tx_pkt.kind[7:6] === 2'h2) begin
                rpt_q.push_back(tx_pkt);
                rpt_t.push_back(cyc);
            end else
                ans_q.push_back(tx_pkt);
        end
        if (screen_char_memory_we === 1'h1 && screen_char_memory_wdata === BLANK_CHAR
            && screen_char_memory_addr === 7'(blanks)) blanks++;
        if (cursor_home === 1'h1) homes++;
        if (cyc == 90000) begin
            err_total++;
            summarize();
        end
    end
    task automatic chk(input string s, input logic [127:0] seen, input logic [127:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %0s expected %0h seen %0h", s, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic send(input logic [7:0] k, input logic [7:0] l, input logic [175:0] d);
        int w;
        w = 0;
        @(negedge clk);
        while (cmd_busy !== 1'h0 && w < 40000) begin
            @(negedge clk);
            w++;
        end
        @(posedge clk);
        cmd_pkt <= {k, l, d};
        cmd_valid <= 1'h1;
        @(posedge clk);
        cmd_valid <= 1'h0;
    endtask
    task automatic ans(input string s, input logic [7:0] k, input int l, input logic [127:0] d, input int lim);
        pkt_t p;
        int w;
        w = 0;
        while (ans_q.size() == 0 && w < lim) begin
            @(negedge clk);
            w++;
        end
        p = ans_q.size() > 0 ? ans_q.pop_front() : '0;
        chk(s, p.kind, k);
        if (l >= 0) chk(s, p.len, l);
        if (l > 0) chk(s, p.data[175:48] >> (8 * (16 - l)), d >> (8 * (16 - l)));
        $display("test %0s done", s);
    endtask
    task automatic hold_len(input logic pwr, output int len);
        int w;
        w = 0;
        len = 0;
        while ((pwr ? host_power_drive : host_reset_drive) !== 1'h1 && w < 1000) begin
            @(negedge clk);
            w++;
        end
        while ((pwr ? host_power_drive : host_reset_drive) === 1'h1 && len < 20000) begin
            @(negedge clk);
            len++;
        end
    endtask
    function automatic int find(input logic [7:0] k, input logic [7:0] idx, input int nth);
        int c;
        c = 0;
        foreach (rpt_q[i])
            if (rpt_q[i].kind === k && rpt_q[i].data[175:168] === idx) begin
                if (c == nth) return i;
                c++;
            end
        return -1;
    endfunction
    initial begin
        foreach (fan_meas[i]) fan_meas[i] = {8'h33, 16'h1234};
        foreach (temp_meas[i]) temp_meas[i] = {16'hFE12, 1'h1};
        repeat (4) @(negedge clk);
        chk("load at reset", cfg_load_req, 1);
        @(posedge clk);
        sys_rst <= 1'h0;
        n = 0;
        while (fans_on !== 1'h1 && n < 6000) begin
            @(negedge clk);
            n++;
        end
        chk("fan start delay", n >= FAN_DELAY_MS * MS - 10 && n <= FAN_DELAY_MS * MS + 10, 1);
        send(8'h00, 8'h10, PAT);
        ans("ping16", 8'h40, 16, PAT[175:48], 250 * MS);
        slow <= 1'h0;
        send(8'h00, 8'h00, PAT);
        ans("ping0", 8'h40, 0, '0, 250 * MS);
        send(8'h01, 8'h00, '0);
        ans("version", 8'h41, 16, VER, 250 * MS);
        send(8'h02, 8'h10, ~PAT);
        ans("user write", 8'h42, 0, '0, 250 * MS);
        send(8'h03, 8'h00, '0);
        ans("user read", 8'h43, 16, ~PAT[175:48], 250 * MS);
        send(8'h04, 8'h00, '0);
        ans("save", 8'h44, 0, '0, 250 * MS);
        save_good <= 1'h0;
        send(8'h04, 8'h00, '0);
        ans("save mismatch", 8'hC4, -1, '0, 250 * MS);
        send(8'h06, 8'h00, '0);
        ans("clear", 8'h46, 0, '0, 250 * MS);
        chk("blank cells", blanks, SCREEN_CELLS);
        chk("cursor home", homes, 1);
        foreach (BAD[i]) begin
            send(BAD[i][15:8], BAD[i][7:0], '0);
            ans("refused", 8'hC0 | BAD[i][15:8], -1, '0, 250 * MS);
        end
        send(8'h05, 8'h03, {24'h030B5F, 152'h0});
        ans("power off", 8'h45, 0, '0, 250 * MS);
        hold_len(1'h1, n);
        chk("power pulse", n >= PWR_MS * MS - 10 && n <= PWR_MS * MS, 1);
        send(8'h05, 8'h03, {24'h0C1C61, 152'h0});
        ans("host reset", 8'h45, 0, '0, 250 * MS);
        hold_len(1'h0, n);
        chk("reset pulse", n >= HRST_PULSE_MS * MS - 10 && n <= HRST_PULSE_MS * MS, 1);
        send(8'h05, 8'h03, {24'h081263, 152'h0});
        ans("reboot", 8'h45, 0, '0, BOOT_ACK_MS * MS);
        // reporting is switched on for the first time once the reboots are over
        for (int r = 0; r < 2; r++) begin
            @(posedge clk);
            fan_report_en <= 4'h5;
            temp_report_en <= 32'h80000000;
            board_present <= r == 0;
            temp_meas[31] <= {16'hFE12, r == 0};
            repeat (10) @(negedge clk);
            rpt_q.delete();
            rpt_t.delete();
            repeat (FAN_PERIOD_MS * MS * 2 + 100) @(negedge clk);
            a = find(T_FAN_RPT, 8'h02, 0);
            b = find(T_FAN_RPT, 8'h02, 1);
            chk("fan report", {rpt_q[a].len, rpt_q[a].data[175:144]}, {8'h04, 8'h02, r ? 24'h0 : 24'h331234});
            chk("fan period", a >= 0 && b >= 0 && rpt_t[b] - rpt_t[a] inside {[4990:5010]}, 1);
            chk("fan off", find(T_FAN_RPT, 8'h01, 0), -1);
            a = find(T_TEMP_RPT, 8'h1F, 0);
            if (r == 0) chk("temp report", {rpt_q[a].len, rpt_q[a].data[175:152]}, {8'h04, 8'h1F, 16'hFE12});
            chk("temp status", rpt_q[a].data[151:144], r ? 8'h00 : 8'h01);
            chk("temp off", find(T_TEMP_RPT, 8'h00, 0), -1);
            $display("test reports round %0d done", r);
        end
        summarize();
    end
endmodule
